// *** inc/uep0_pkg.sv ***
package uep0_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W          = 16;
  localparam int unsigned DATA_W          = 8;
  localparam logic [15:0] ADDR_OUT_CFG    = 16'hff82;
  localparam logic [15:0] ADDR_OUT_CNT    = 16'hff83;
  localparam logic [15:0] ADDR_FUNC_ADDR  = 16'hff84;
  localparam logic [15:0] ADDR_EVT_STATUS = 16'hff85;
  localparam logic [15:0] ADDR_EVT_MASK   = 16'hff86;

  // ------------------------------------------------------------
  // output_ep0_config fields
  // ------------------------------------------------------------
  localparam int unsigned CFG_IE_BIT      = 2;
  localparam int unsigned CFG_STALL_BIT   = 3;
  localparam int unsigned CFG_TOGGLE_BIT  = 5;
  localparam int unsigned CFG_BM_EN_BIT   = 7;

  // ------------------------------------------------------------
  // output_ep0_byte_count fields
  // ------------------------------------------------------------
  localparam int unsigned CNT_LSB         = 0;
  localparam int unsigned CNT_W           = 4;
  localparam int unsigned CNT_NAK_BIT     = 7;
  localparam logic [3:0]  CNT_MAX         = 4'h8;
  localparam logic [3:0]  CNT_RST         = 4'h0;
  localparam logic        NAK_RST         = 1'b1;

  // ------------------------------------------------------------
  // function_address fields
  // ------------------------------------------------------------
  localparam int unsigned FA_W            = 7;
  localparam logic [6:0]  FA_RST          = 7'h00;

  // ------------------------------------------------------------
  // usb_event_status / usb_event_mask fields
  // ------------------------------------------------------------
  localparam int unsigned EV_OVERWRITE    = 0;
  localparam int unsigned EV_SETUP        = 2;
  localparam int unsigned EV_PWR_ON       = 3;
  localparam int unsigned EV_PWR_OFF      = 4;
  localparam int unsigned EV_RESUME       = 5;
  localparam int unsigned EV_SUSPEND      = 6;
  localparam int unsigned EV_FUNC_RESET   = 7;
  localparam logic [7:0]  EV_IMPL_MASK    = 8'hfd;
  localparam logic [7:0]  EV_RST          = 8'h00;
  localparam logic [7:0]  MASK_RST        = 8'h00;

endpackage

// *** rtl/uep0_regs.sv ***
`timescale 1ns/1ps
// What this block does
// R1: transaction interrupt only when enable bit set
// R2: stall bit makes endpoint answer STALL
// R3: next setup clears stall bit automatically
// R4: read-only data toggle follows packet exchange
// R5: buffer manager uses endpoint only when enabled
// R6: byte count above eight goes to the engine as eight, reads back unclamped
// R7: nak set on stored packet, MCU clears
// R8: seven-bit function address written by MCU
// R9: status set by hardware, write-one clears
// R10: status bit with mask raises interrupt
// R11: mask mirrors status layout, resets zero
// R12: setup overwrite flag on busy buffer
// R13: setup flag forces NAK on endpoint-0
// R14: power-on request flag for port 3
// R15: power-off request flag for port 3
// R16: resume flag on resume signalling
// R17: suspend flag on global or selective
// R18: reset flag, untouched by function reset
// R19: reserved bits read zero, ignore writes
// R20: hardware set beats same-cycle clear
module uep0_regs
  import uep0_pkg::*;
(
  // clock, reset, enable
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire logic              ce,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // serial engine events
  input  wire logic              usb_func_rst,
  input  wire logic              setup_rx,
  input  wire logic              setup_buf_full,
  input  wire logic              host_out_valid,
  input  wire logic [3:0]        host_out_len,
  input  wire logic              port3_power_on_req,
  input  wire logic              port3_power_off_req,
  input  wire logic              resume_det,
  input  wire logic              global_suspend_det,
  input  wire logic              selective_suspend_det,
  input  wire logic              port_reset_det,
  // serial engine answers
  output logic                   ep0_out_ack,
  output logic                   ep0_out_nak,
  output logic                   ep0_out_stall,
  output logic                   ep0_in_force_nak,
  output logic                   buffer_manager_enable,
  output logic      [3:0]        ep0_out_count,
  output logic      [FA_W-1:0]   function_addr,
  // interrupt requests
  output logic                   ep0_out_xfer_irq,
  output logic                   usb_event_irq
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic              irq_enable_q;
  logic              irq_enable_d;
  logic              stall_q;
  logic              stall_d;
  logic              data_toggle_q;
  logic              data_toggle_d;
  logic              bm_enable_q;
  logic              bm_enable_d;
  logic [CNT_W-1:0]  count_q;
  logic [CNT_W-1:0]  count_d;
  logic [CNT_W-1:0]  count_out_q;
  logic [CNT_W-1:0]  count_out_d;
  logic              nak_q;
  logic              nak_d;
  logic [FA_W-1:0]   func_addr_q;
  logic [FA_W-1:0]   func_addr_d;
  logic [7:0]        status_q;
  logic [7:0]        status_d;
  logic [7:0]        mask_q;
  logic [7:0]        mask_d;
  logic              xfer_irq_q;
  logic              xfer_irq_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  wire logic sel_cfg;
  wire logic sel_cnt;
  wire logic sel_fa;
  wire logic sel_sta;
  wire logic sel_msk;
  wire logic wr_cfg;
  wire logic wr_cnt;
  wire logic wr_fa;
  wire logic wr_sta;
  wire logic wr_msk;

  assign sel_cfg = (reg_addr == ADDR_OUT_CFG);
  assign sel_cnt = (reg_addr == ADDR_OUT_CNT);
  assign sel_fa  = (reg_addr == ADDR_FUNC_ADDR);
  assign sel_sta = (reg_addr == ADDR_EVT_STATUS);
  assign sel_msk = (reg_addr == ADDR_EVT_MASK);
  assign wr_cfg  = reg_wr & sel_cfg;
  assign wr_cnt  = reg_wr & sel_cnt;
  assign wr_fa   = reg_wr & sel_fa;
  assign wr_sta  = reg_wr & sel_sta;
  assign wr_msk  = reg_wr & sel_msk;

  // ------------------------------------------------------------
  // write data fields
  // ------------------------------------------------------------
  wire logic             wd_irq_enable;
  wire logic             wd_stall;
  wire logic             wd_bm_enable;
  wire logic [CNT_W-1:0] wd_count;
  wire logic             wd_nak;
  wire logic [FA_W-1:0]  wd_func_addr;
  wire logic [7:0]       wd_mask;

  assign wd_irq_enable = reg_wdata[CFG_IE_BIT];
  assign wd_stall      = reg_wdata[CFG_STALL_BIT];
  assign wd_bm_enable  = reg_wdata[CFG_BM_EN_BIT];
  assign wd_count      = reg_wdata[CNT_LSB +: CNT_W];
  assign wd_nak        = reg_wdata[CNT_NAK_BIT];
  assign wd_func_addr  = reg_wdata[FA_W-1:0];
  // reserved enable position never takes a one
  assign wd_mask       = reg_wdata & EV_IMPL_MASK;        // R11

  // ------------------------------------------------------------
  // endpoint acceptance
  // ------------------------------------------------------------
  wire logic setup_pending;
  wire logic accept;

  assign setup_pending = status_q[EV_SETUP];
  // packet stored only when endpoint is free and owned by the manager
  assign accept = host_out_valid & ~nak_q & ~stall_q & ~setup_pending // R13
                  & bm_enable_q;                                      // R5

  // ------------------------------------------------------------
  // endpoint configuration next state
  // ------------------------------------------------------------
  assign irq_enable_d = wr_cfg ? wd_irq_enable : irq_enable_q;
  assign bm_enable_d  = wr_cfg ? wd_bm_enable : bm_enable_q;

  // setup clears stall even against a same-cycle write of one
  assign stall_d = setup_rx ? 1'b0                         // R3
                 : wr_cfg   ? wd_stall                     // R2
                 : stall_q;

  // setup restarts at DATA1 for the data stage, each stored packet flips
  assign data_toggle_d = setup_rx ? 1'b1                   // R4
                       : accept   ? ~data_toggle_q         // R4
                       : data_toggle_q;

  // ------------------------------------------------------------
  // byte count and nak next state
  // ------------------------------------------------------------
  assign count_d = accept ? host_out_len
                 : wr_cnt ? wd_count
                 : count_q;

  assign nak_d = accept ? 1'b1                             // R7
               : wr_cnt ? wd_nak                           // R7
               : nak_q;

  // clamped at the register so the engine sees a flop output
  assign count_out_d = (count_d > CNT_MAX) ? CNT_MAX : count_d; // R6

  // ------------------------------------------------------------
  // function address next state
  // ------------------------------------------------------------
  assign func_addr_d = wr_fa ? wd_func_addr : func_addr_q; // R8

  // ------------------------------------------------------------
  // event status next state
  // ------------------------------------------------------------
  logic [7:0] ev_set;
  logic [7:0] ev_clr;

  always_comb
  begin
    ev_set                = 8'h00;
    ev_set[EV_OVERWRITE]  = setup_rx & setup_buf_full;     // R12
    ev_set[EV_SETUP]      = setup_rx;                      // R13
    ev_set[EV_PWR_ON]     = port3_power_on_req;            // R14
    ev_set[EV_PWR_OFF]    = port3_power_off_req;           // R15
    ev_set[EV_RESUME]     = resume_det;                    // R16
    ev_set[EV_SUSPEND]    = global_suspend_det             // R17
                            | selective_suspend_det;       // R17
    ev_set[EV_FUNC_RESET] = port_reset_det;                // R18
  end

  assign ev_clr = wr_sta ? reg_wdata : 8'h00;              // R9

  // one flag per implemented bit, reserved bit 1 tied low; a set in the same cycle as its clear survives
  for (genvar i = 0; i < 8; i++)
  begin : g_status
    if (EV_IMPL_MASK[i])
    begin : g_flag
      assign status_d[i] = ev_set[i] | (status_q[i] & ~ev_clr[i]); // R20
    end
    else
    begin : g_rsvd
      assign status_d[i] = 1'b0;                           // R19
    end
  end

  assign mask_d = wr_msk ? wd_mask : mask_q;               // R11

  // ------------------------------------------------------------
  // transaction completion interrupt
  // ------------------------------------------------------------
  assign xfer_irq_d = accept & irq_enable_q;               // R1

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  wire logic [7:0] rd_cfg;
  wire logic [7:0] rd_cnt;
  wire logic [7:0] rd_fa;
  wire logic [7:0] rd_sta;
  wire logic [7:0] rd_msk;
  wire logic [7:0] rd_mux;

  // reserved bits are tied low in every read image
  assign rd_cfg = {bm_enable_q, 1'b0, data_toggle_q, 1'b0,   // R19
                   stall_q, irq_enable_q, 2'b00};          // R4
  assign rd_cnt = {nak_q, 3'b000, count_q};                // R19
  assign rd_fa  = {1'b0, func_addr_q};                     // R19
  assign rd_sta = status_q & EV_IMPL_MASK;                 // R19
  assign rd_msk = mask_q & EV_IMPL_MASK;                   // R19

  assign rd_mux = sel_cfg ? rd_cfg
                : sel_cnt ? rd_cnt
                : sel_fa  ? rd_fa
                : sel_sta ? rd_sta
                : sel_msk ? rd_msk
                : 8'h00;

  assign rdata_d = reg_rd ? rd_mux : 8'h00;

  // ------------------------------------------------------------
  // endpoint configuration register
  // ------------------------------------------------------------
  // function reset returns endpoint and address state to defaults;
  // it only acts on an enabled cycle, rstn acts always
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || (ce && usb_func_rst))
    begin
      irq_enable_q  <= 1'b0;
      stall_q       <= 1'b0;
      data_toggle_q <= 1'b0;
      bm_enable_q   <= 1'b0;
    end
    else if (ce)
    begin
      irq_enable_q  <= irq_enable_d;
      stall_q       <= stall_d;
      data_toggle_q <= data_toggle_d;
      bm_enable_q   <= bm_enable_d;
    end
  end

  // ------------------------------------------------------------
  // byte count register
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || (ce && usb_func_rst))
    begin
      count_q     <= CNT_RST;
      count_out_q <= CNT_RST;
      nak_q       <= NAK_RST;
    end
    else if (ce)
    begin
      count_q     <= count_d;
      count_out_q <= count_out_d;
      nak_q       <= nak_d;
    end
  end

  // ------------------------------------------------------------
  // function address register
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || (ce && usb_func_rst))
    begin
      func_addr_q <= FA_RST;
    end
    else if (ce)
    begin
      func_addr_q <= func_addr_d;
    end
  end

  // ------------------------------------------------------------
  // event mask register
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || (ce && usb_func_rst))
    begin
      mask_q <= MASK_RST;
    end
    else if (ce)
    begin
      mask_q <= mask_d;
    end
  end

  // ------------------------------------------------------------
  // status register
  // ------------------------------------------------------------
  // kept apart so a function reset never wipes pending events
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      status_q <= EV_RST;
    end
    else if (ce)
    begin
      status_q <= status_d;                                // R18
    end
  end

  // ------------------------------------------------------------
  // output flops
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      xfer_irq_q <= 1'b0;
    end
    else if (ce)
    begin
      xfer_irq_q <= xfer_irq_d;
    end
  end

  // read data stands for one cycle only, zero otherwise
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      rdata_q <= 8'h00;
    end
    else if (ce)
    begin
      rdata_q <= rdata_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign reg_rdata             = rdata_q;
  assign ep0_out_ack           = accept & ce;
  assign ep0_out_stall         = stall_q;                  // R2
  assign ep0_out_nak           = nak_q | setup_pending     // R7
                                 | ~bm_enable_q;           // R5
  assign ep0_in_force_nak      = setup_pending;            // R13
  assign buffer_manager_enable = bm_enable_q;              // R5
  assign ep0_out_count         = count_out_q;              // R6
  assign function_addr         = func_addr_q;              // R8
  assign ep0_out_xfer_irq      = xfer_irq_q;               // R1
  assign usb_event_irq         = |(status_q & mask_q);     // R10

endmodule // uep0_regs

// *** bench/uep0_regs_sva.sv ***
`timescale 1ns/1ps
module uep0_regs_sva
  import uep0_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        ce,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // engine side
  input wire logic        usb_func_rst,
  input wire logic        setup_rx,
  input wire logic        host_out_valid,
  input wire logic        ep0_out_ack,
  input wire logic        ep0_out_nak,
  input wire logic        ep0_out_stall,
  input wire logic        ep0_in_force_nak,
  input wire logic        buffer_manager_enable,
  input wire logic [3:0]  ep0_out_count,
  input wire logic [6:0]  function_addr,
  input wire logic        ep0_out_xfer_irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_ack_gated: assert property (ep0_out_ack |-> host_out_valid && buffer_manager_enable
    && !ep0_out_stall && !ep0_out_nak) else $error("ack while gated");
  a_nak_after_ack: assert property (ep0_out_ack |=> ep0_out_nak)
    else $error("nak not set after packet");
  a_setup_stall: assert property (setup_rx && ce |=> !ep0_out_stall && ep0_in_force_nak
    && ep0_out_nak) else $error("setup did not clear stall or force nak");
  a_force_no_ack: assert property (ep0_in_force_nak |-> !ep0_out_ack)
    else $error("ack while setup flag set");
  a_irq_cause: assert property (ep0_out_xfer_irq |-> $past(ep0_out_ack))
    else $error("irq without packet");
  a_irq_single: assert property (ep0_out_xfer_irq |=> !ep0_out_xfer_irq)
    else $error("irq longer than one cycle");
  a_count_clamp: assert property (ep0_out_count <= 4'h8)
    else $error("count above eight");
  a_addr_stable: assert property (!reg_wr && !usb_func_rst |=> $stable(function_addr))
    else $error("address changed without write");
  a_rsvd_read: assert property (reg_rd && ce && reg_addr == ADDR_EVT_STATUS
    |=> reg_rdata[1] == 1'b0) else $error("reserved status bit set");

  c_ack: cover property (ep0_out_ack);
  c_setup: cover property (setup_rx ##1 ep0_in_force_nak);
  c_irq: cover property (ep0_out_xfer_irq);
endmodule // uep0_regs_sva

bind uep0_regs uep0_regs_sva sva_u (.clk_sys, .rstn, .ce, .reg_addr, .reg_wr, .reg_rd,
  .reg_rdata, .usb_func_rst, .setup_rx, .host_out_valid, .ep0_out_ack, .ep0_out_nak,
  .ep0_out_stall, .ep0_in_force_nak, .buffer_manager_enable, .ep0_out_count,
  .function_addr, .ep0_out_xfer_irq);

// *** bench/uep0_host.sv ***
`timescale 1ns/1ps
module uep0_host
(
  // clock and answer
  input  wire logic       clk_sys,
  input  wire logic       ep0_out_ack,
  // host traffic
  output logic            setup_rx,
  output logic            setup_buf_full,
  output logic            host_out_valid,
  output logic [3:0]      host_out_len
);
  initial
  begin
    setup_rx       = 1'b0;
    setup_buf_full = 1'b0;
    host_out_valid = 1'b0;
    host_out_len   = 4'h0;
  end

  // one data packet offer; len shows the inverse once released
  task automatic send_out(input logic [3:0] len, output logic acked);
    @(posedge clk_sys);
    host_out_valid <= 1'b1;
    host_out_len   <= len;
    @(posedge clk_sys);
    acked = ep0_out_ack;
    host_out_valid <= 1'b0;
    host_out_len   <= ~len;
  endtask

  task automatic send_setup(input logic full);
    @(posedge clk_sys);
    setup_rx       <= 1'b1;
    setup_buf_full <= full;
    @(posedge clk_sys);
    setup_rx       <= 1'b0;
    setup_buf_full <= ~full;
  endtask
endmodule // uep0_host

// *** bench/uep0_regs_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module uep0_regs_tb
  import uep0_pkg::*;
;
  logic        clk_sys, rstn, ce, reg_wr, reg_rd, usb_func_rst;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [5:0]  ev;
  logic        setup_rx, setup_buf_full, host_out_valid, ep0_out_ack, ep0_out_nak;
  logic        ep0_out_stall, ep0_in_force_nak, buffer_manager_enable;
  logic        ep0_out_xfer_irq, usb_event_irq;
  logic [3:0]  host_out_len, ep0_out_count;
  logic [6:0]  function_addr;
  int          errors, tests_run;

  uep0_regs dut_u (.clk_sys, .rstn, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .usb_func_rst, .setup_rx, .setup_buf_full, .host_out_valid,
    .host_out_len, .port3_power_on_req(ev[0]), .port3_power_off_req(ev[1]),
    .resume_det(ev[2]), .global_suspend_det(ev[3]), .selective_suspend_det(ev[4]),
    .port_reset_det(ev[5]), .ep0_out_ack, .ep0_out_nak, .ep0_out_stall,
    .ep0_in_force_nak, .buffer_manager_enable, .ep0_out_count, .function_addr,
    .ep0_out_xfer_irq, .usb_event_irq);
  uep0_host host_u (.clk_sys, .ep0_out_ack, .setup_rx, .setup_buf_full,
    .host_out_valid, .host_out_len);

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask

  task automatic pulse(input logic [5:0] m);
    @(posedge clk_sys);
    ev <= m;
    @(posedge clk_sys);
    ev <= 6'h00;
  endtask

  task automatic t_reset;
    rd(ADDR_OUT_CFG, 8'h00);
    rd(ADDR_OUT_CNT, 8'h80);
    rd(ADDR_FUNC_ADDR, 8'h00);
    rd(ADDR_EVT_STATUS, 8'h00);
    rd(ADDR_EVT_MASK, 8'h00);
    rd(16'hff87, 8'h00);
    $display("t_reset done");
  endtask

  task automatic t_out;
    logic a;
    wr(ADDR_OUT_CFG, 8'hff);
    rd(ADDR_OUT_CFG, 8'h8c);
    wr(ADDR_OUT_CNT, 8'h00);
    `CHK(ep0_out_stall, 1'b1)
    host_u.send_out(4'h5, a);
    `CHK(a, 1'b0)
    wr(ADDR_OUT_CFG, 8'h84);
    host_u.send_out(4'h5, a);
    #1 `CHK(ep0_out_xfer_irq, 1'b1)
    `CHK(a, 1'b1)
    `CHK(ep0_out_nak, 1'b1)
    rd(ADDR_OUT_CNT, 8'h85);
    rd(ADDR_OUT_CFG, 8'ha4);
    host_u.send_out(4'h2, a);
    `CHK(a, 1'b0)
    $display("t_out done");
  endtask

  task automatic t_gate;
    logic a;
    wr(ADDR_OUT_CFG, 8'h00);
    wr(ADDR_OUT_CNT, 8'h0b);
    #1 `CHK(ep0_out_count, 4'h8)
    `CHK(buffer_manager_enable, 1'b0)
    `CHK(ep0_out_nak, 1'b1)
    host_u.send_out(4'h3, a);
    `CHK(a, 1'b0)
    wr(ADDR_OUT_CFG, 8'h80);
    #1 `CHK(buffer_manager_enable, 1'b1)
    host_u.send_out(4'h9, a);
    #1 `CHK(ep0_out_xfer_irq, 1'b0)
    `CHK(a, 1'b1)
    `CHK(ep0_out_count, 4'h8)
    $display("t_gate done");
  endtask

  task automatic t_setup;
    logic a;
    wr(ADDR_OUT_CFG, 8'h88);
    wr(ADDR_OUT_CNT, 8'h00);
    host_u.send_setup(1'b1);
    #1 `CHK(ep0_out_stall, 1'b0)
    `CHK(ep0_in_force_nak, 1'b1)
    rd(ADDR_EVT_STATUS, 8'h05);
    host_u.send_out(4'h1, a);
    `CHK(a, 1'b0)
    rd(ADDR_OUT_CFG, 8'ha0);
    wr(ADDR_EVT_STATUS, 8'h00);
    rd(ADDR_EVT_STATUS, 8'h05);
    wr(ADDR_EVT_STATUS, 8'h05);
    rd(ADDR_EVT_STATUS, 8'h00);
    $display("t_setup done");
  endtask

  task automatic t_events;
    logic [7:0] b [6] = '{8'h08, 8'h10, 8'h20, 8'h40, 8'h40, 8'h80};
    wr(ADDR_EVT_MASK, 8'hff);
    rd(ADDR_EVT_MASK, 8'hfd);
    for (int i = 0; i < 6; i++)
    begin
      pulse(6'h01 << i);
      rd(ADDR_EVT_STATUS, b[i]);
      `CHK(usb_event_irq, 1'b1)
      wr(ADDR_EVT_STATUS, b[i]);
    end
    #1 `CHK(usb_event_irq, 1'b0)
    wr(ADDR_EVT_MASK, 8'h00);
    pulse(6'h20);
    rd(ADDR_EVT_STATUS, 8'h80);
    `CHK(usb_event_irq, 1'b0)
    $display("t_events done");
  endtask

  task automatic t_race;
    @(posedge clk_sys);
    ev        <= 6'h20;
    reg_wr    <= 1'b1;
    reg_addr  <= ADDR_EVT_STATUS;
    reg_wdata <= 8'h80;
    @(posedge clk_sys);
    ev        <= 6'h00;
    reg_wr    <= 1'b0;
    rd(ADDR_EVT_STATUS, 8'h80);
    wr(ADDR_FUNC_ADDR, 8'hff);
    rd(ADDR_FUNC_ADDR, 8'h7f);
    `CHK(function_addr, 7'h7f)
    @(posedge clk_sys);
    usb_func_rst <= 1'b1;
    @(posedge clk_sys);
    usb_func_rst <= 1'b0;
    rd(ADDR_EVT_STATUS, 8'h80);
    rd(ADDR_FUNC_ADDR, 8'h00);
    @(posedge clk_sys);
    ce <= 1'b0;
    wr(ADDR_FUNC_ADDR, 8'h12);
    ce <= 1'b1;
    rd(ADDR_FUNC_ADDR, 8'h00);
    $display("t_race done");
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (4000) @(posedge clk_sys);
    errors++;
    tally_and_finish;
  end

  initial
  begin
    {rstn, reg_wr, reg_rd, usb_func_rst, ev, reg_addr, reg_wdata} = '0;
    ce = 1'b1;
    errors = 0;
    tests_run = 0;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset;
    t_out;
    t_gate;
    t_setup;
    t_events;
    t_race;
    tally_and_finish;
  end
endmodule // uep0_regs_tb
